//--- emacsq_pkg.sv
/*
 * Shared constants for the Ethernet MAC status, flag and queue pointer block:
 * register offsets, bit positions, reset values, queue geometry and bus codes.
 * Assumes the block sits on a 32-bit AXI4-Lite slave port with byte addresses.
 */
// Overview of operation
// - Network status bit 1 reads the live, synchronised management data input pin.
// - Network status bit 2 reads 0 while management is busy, 1 when idle.
// - Transmit and receive status flags clear on writing one; writes never set them.
// - A transmit descriptor fetched with used bit sets transmit and interrupt used flags.
// - Collision sets its sticky flag; retry limit flag stays set until written one.
// - Transmit status bit 3 reads the live transmit-active level, never sticky.
// - Buffers exhausted mid frame halts transmit, forces bad FCS, raises tx_er, sets flag.
// - Transmit complete flag sets per frame sent and holds until written one.
// - DMA underrun (late grant, bus error, mid-frame used bit) sets flag, forces bad CRC.
// - Queue pointers load start on write, advance per buffer, wrap at 1024 or wrap bit.
// - Transmit pointer writes are ignored while transmit-active is high.
// - Transmit pointer reads the first buffer of the current or next frame.
// - Receive buffer unavailable sets its flag each failed attempt; refetch each new frame.
// - Frame received flag sets when frames are stored and holds until written one.
// - Receive DMA store failure sets overrun flag and recovers the buffer in use.
// - Management done interrupt flag sets on completion, clears on status read.
// - Receive complete interrupt flag sets on frame stored, clears on status read.
// - Receive used bit interrupt flag sets on used descriptor fetch, clears on read.
package emacsq_pkg;
	localparam logic [7:0]  OFF_NETWORK_STATUS  = 8'h08;
	localparam logic [7:0]  OFF_TRANSMIT_STATUS = 8'h14;
	localparam logic [7:0]  OFF_RX_QUEUE_PTR    = 8'h18;
	localparam logic [7:0]  OFF_TX_QUEUE_PTR    = 8'h1C;
	localparam logic [7:0]  OFF_RECEIVE_STATUS  = 8'h20;
	localparam logic [7:0]  OFF_INTERRUPT_STAT  = 8'h24;

	localparam int          NSR_MDIO_BIT = 1;
	localparam int          NSR_IDLE_BIT = 2;

	localparam int          TSR_TX_USED_BIT   = 0;
	localparam int          TSR_COL_BIT       = 1;
	localparam int          TSR_RETRY_LIM_BIT = 2;
	localparam int          TSR_TX_ACTIVE_BIT = 3;
	localparam int          TSR_EXHAUST_BIT   = 4;
	localparam int          TSR_COMP_BIT      = 5;
	localparam int          TSR_UNDERRUN_BIT  = 6;
	localparam int          TSR_WIDTH         = 7;

	localparam int          RSR_UNAVAIL_BIT  = 0;
	localparam int          RSR_RECEIVED_BIT = 1;
	localparam int          RSR_OVERRUN_BIT  = 2;
	localparam int          RSR_WIDTH        = 3;

	localparam int          ISR_MGMT_DONE_BIT = 0;
	localparam int          ISR_RX_DONE_BIT   = 1;
	localparam int          ISR_RX_USED_BIT   = 2;
	localparam int          ISR_TX_USED_BIT   = 3;
	localparam int          ISR_TUND_BIT  = 4;
	localparam int          ISR_RETRY_LIM_BIT = 5;
	localparam int          ISR_TXERR_BIT = 6;
	localparam int          ISR_TCOMP_BIT = 7;
	localparam int          ISR_ROVR_BIT  = 10;
	localparam int          ISR_HRESP_BIT = 11;
	localparam int          ISR_WIDTH     = 14;

	localparam logic [TSR_WIDTH-1:0] TSR_RESET  = 7'h00;
	localparam logic [RSR_WIDTH-1:0] RSR_RESET  = 3'h0;
	localparam logic [ISR_WIDTH-1:0] ISR_RESET  = 14'h0000;
	localparam logic [31:0]          QPTR_RESET = 32'h0000_0000;
	localparam logic [31:0]          QPTR_MASK  = 32'hFFFF_FFFC;

	localparam int          QUEUE_IDX_W    = 10;
	localparam logic [9:0]  QUEUE_LAST_IDX = 10'h3FF;
	localparam logic [31:0] DESC_BYTES     = 32'h0000_0008;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : emacsq_pkg

//--- emacsq_qptr.sv
/*
 * One buffer descriptor queue pointer: start address, current entry and the
 * first entry of the frame in progress.
 * Assumes load, advance, wrap and mark are single-cycle pulses on aclk.
 */
`timescale 1ns/10ps
module emacsq_qptr (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        load,
	input  wire logic [31:0] load_addr,
	input  wire logic        advance,
	input  wire logic        wrap,
	input  wire logic        mark,
	output logic      [31:0] cur,
	output logic      [31:0] first
);
	logic [31:0]                        start;
	logic [31:0]                        next_start;
	logic [31:0]                        next_cur;
	logic [31:0]                        next_first;
	logic [emacsq_pkg::QUEUE_IDX_W-1:0] idx;
	logic [emacsq_pkg::QUEUE_IDX_W-1:0] next_idx;

	always_comb begin
		next_start = start;
		next_cur   = cur;
		next_idx   = idx;
		if (load) begin
			next_start = load_addr & emacsq_pkg::QPTR_MASK;
			next_cur   = load_addr & emacsq_pkg::QPTR_MASK;
			next_idx   = '0;
		end else if (advance) begin
			if (wrap || idx == emacsq_pkg::QUEUE_LAST_IDX) begin
				next_cur = start;
				next_idx = '0;
			end else begin
				next_cur = cur + emacsq_pkg::DESC_BYTES;
				next_idx = idx + 10'h001;
			end
		end
		next_first = first;
		if (load || mark) begin
			next_first = next_cur;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start <= emacsq_pkg::QPTR_RESET;
			cur   <= emacsq_pkg::QPTR_RESET;
			first <= emacsq_pkg::QPTR_RESET;
			idx   <= '0;
		end else begin
			start <= next_start;
			cur   <= next_cur;
			first <= next_first;
			idx   <= next_idx;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_qptr_wrap_start: assert property (!load && advance && (wrap || idx == 10'h3FF) |=>
		cur == start) else $error("queue pointer did not return to start");
	chk_qptr_step_eight: assert property (!load && advance && !wrap && idx != 10'h3FF |=>
		cur == $past(cur) + 32'h0000_0008) else $error("queue pointer step is not one entry");
	chk_qptr_first_mark: assert property (!load && mark |=> first == cur)
		else $error("first-buffer pointer not taken at frame boundary");
	cov_qptr_wrap: cover property (advance && idx == 10'h3FF);
endmodule : emacsq_qptr

//--- emacsq_top.sv
/*
 * Ethernet MAC status registers, sticky transmit and receive flags, the
 * clear-on-read interrupt status flags and both descriptor queue pointers,
 * behind an AXI4-Lite slave.
 * Assumes event inputs are one-cycle pulses from engines on aclk; mdio_in and
 * collision come from pins and are synchronised here.
 */
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module emacsq_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        mdio_in,
	input  wire logic        collision,
	input  wire logic        mgmt_busy,
	input  wire logic        mgmt_done_evt,
	input  wire logic        tx_active,
	input  wire logic        tx_used_bit_evt,
	input  wire logic        retry_limit_evt,
	input  wire logic        tx_buf_exhausted_evt,
	input  wire logic        tx_complete_evt,
	input  wire logic        tx_underrun_evt,
	input  wire logic        tx_buf_used,
	input  wire logic        tx_desc_wrap,
	input  wire logic        rx_buf_unavail_evt,
	input  wire logic        rx_desc_ok,
	input  wire logic        rx_frame_stored_evt,
	input  wire logic        rx_overrun_evt,
	input  wire logic        rx_used_bit_evt,
	input  wire logic        rx_buf_used,
	input  wire logic        rx_desc_wrap,
	input  wire logic        bus_error_evt,
	output logic [31:0]      rx_desc_addr,
	output logic [31:0]      tx_desc_addr,
	output logic             tx_halt,
	output logic             tx_bad_crc,
	output logic             tx_er,
	output logic             rx_refetch,
	output logic             rx_buf_recover
);
	logic                                  mdio_meta;
	logic                                  mdio_sync;
	logic                                  col_meta;
	logic                                  col_sync;
	logic                                  aw_held;
	logic                                  next_aw_held;
	logic [7:0]                            aw_addr;
	logic [7:0]                            next_aw_addr;
	logic                                  w_held;
	logic                                  next_w_held;
	logic [31:0]                           w_data;
	logic [31:0]                           next_w_data;
	logic [3:0]                            w_strb;
	logic [3:0]                            next_w_strb;
	logic                                  next_bvalid;
	logic [1:0]                            next_bresp;
	logic                                  next_rvalid;
	logic [31:0]                           next_rdata;
	logic [1:0]                            next_rresp;
	logic                                  wr_fire;
	logic                                  rd_fire;
	logic [31:0]                           wr_bits;
	logic [emacsq_pkg::TSR_WIDTH-1:0]      tsr_flag;
	logic [emacsq_pkg::TSR_WIDTH-1:0]      next_tsr_flag;
	logic [emacsq_pkg::TSR_WIDTH-1:0]      tsr_set;
	logic [emacsq_pkg::TSR_WIDTH-1:0]      tsr_clr;
	logic [emacsq_pkg::RSR_WIDTH-1:0]      rsr_flag;
	logic [emacsq_pkg::RSR_WIDTH-1:0]      next_rsr_flag;
	logic [emacsq_pkg::RSR_WIDTH-1:0]      rsr_set;
	logic [emacsq_pkg::RSR_WIDTH-1:0]      rsr_clr;
	logic [emacsq_pkg::ISR_WIDTH-1:0]      isr_flag;
	logic [emacsq_pkg::ISR_WIDTH-1:0]      next_isr_flag;
	logic [emacsq_pkg::ISR_WIDTH-1:0]      isr_set;
	logic                                  isr_read;
	logic                                  next_tx_halt;
	logic                                  next_tx_bad_crc;
	logic                                  next_tx_er;
	logic                                  next_rx_refetch;
	logic                                  next_rx_buf_recover;
	logic                                  tq_load;
	logic                                  rq_load;
	logic [31:0]                           tx_first;

	function automatic logic reg_sel(input logic [7:0] addr, input logic [7:0] off);
		reg_sel = (addr[7:2] == off[7:2]);
	endfunction : reg_sel

	function automatic logic reg_mapped(input logic [7:0] addr);
		reg_mapped = reg_sel(addr, emacsq_pkg::OFF_NETWORK_STATUS)
			|| reg_sel(addr, emacsq_pkg::OFF_TRANSMIT_STATUS)
			|| reg_sel(addr, emacsq_pkg::OFF_RX_QUEUE_PTR)
			|| reg_sel(addr, emacsq_pkg::OFF_TX_QUEUE_PTR)
			|| reg_sel(addr, emacsq_pkg::OFF_RECEIVE_STATUS)
			|| reg_sel(addr, emacsq_pkg::OFF_INTERRUPT_STAT);
	endfunction : reg_mapped

	function automatic logic [31:0] strb_mask(input logic [3:0] strb);
		strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction : strb_mask

	// Pin synchronisers; only the second stage is read by logic.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mdio_meta <= 1'b1;
			mdio_sync <= 1'b1;
			col_meta  <= 1'b0;
			col_sync  <= 1'b0;
		end else begin
			mdio_meta <= mdio_in;
			mdio_sync <= mdio_meta;
			col_meta  <= collision;
			col_sync  <= col_meta;
		end
	end

	// Address and data are held separately so they may arrive in either order.
	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
	assign rd_fire       = s_axi_arvalid && !s_axi_rvalid;
	assign wr_bits       = w_data & strb_mask(w_strb);

	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held  = w_held;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		if (s_axi_awvalid && !aw_held) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = reg_mapped(aw_addr) ? emacsq_pkg::RESP_OKAY : emacsq_pkg::RESP_SLVERR;
		end
	end

	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata  = s_axi_rdata;
		next_rresp  = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (rd_fire) begin
			next_rvalid = 1'b1;
			next_rdata  = 32'h0000_0000;
			next_rresp  = emacsq_pkg::RESP_OKAY;
			if (reg_sel(s_axi_araddr, emacsq_pkg::OFF_NETWORK_STATUS)) begin
				next_rdata[emacsq_pkg::NSR_MDIO_BIT] = mdio_sync;
				next_rdata[emacsq_pkg::NSR_IDLE_BIT] = !mgmt_busy;
			end else if (reg_sel(s_axi_araddr, emacsq_pkg::OFF_TRANSMIT_STATUS)) begin
				next_rdata[emacsq_pkg::TSR_WIDTH-1:0] = tsr_flag;
				next_rdata[emacsq_pkg::TSR_TX_ACTIVE_BIT] = tx_active;
			end else if (reg_sel(s_axi_araddr, emacsq_pkg::OFF_RX_QUEUE_PTR)) begin
				next_rdata = rx_desc_addr;
			end else if (reg_sel(s_axi_araddr, emacsq_pkg::OFF_TX_QUEUE_PTR)) begin
				next_rdata = tx_first;
			end else if (reg_sel(s_axi_araddr, emacsq_pkg::OFF_RECEIVE_STATUS)) begin
				next_rdata[emacsq_pkg::RSR_WIDTH-1:0] = rsr_flag;
			end else if (reg_sel(s_axi_araddr, emacsq_pkg::OFF_INTERRUPT_STAT)) begin
				next_rdata[emacsq_pkg::ISR_WIDTH-1:0] = isr_flag;
			end else begin
				next_rresp = emacsq_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			aw_addr      <= 8'h00;
			w_held       <= 1'b0;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= emacsq_pkg::RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= emacsq_pkg::RESP_OKAY;
		end else begin
			aw_held      <= next_aw_held;
			aw_addr      <= next_aw_addr;
			w_held       <= next_w_held;
			w_data       <= next_w_data;
			w_strb       <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp  <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= next_rresp;
		end
	end

	// Sticky flags: the set term is applied after the clear so a coinciding event survives.
	always_comb begin
		tsr_set = '0;
		tsr_set[emacsq_pkg::TSR_TX_USED_BIT]   = tx_used_bit_evt;
		tsr_set[emacsq_pkg::TSR_COL_BIT]       = col_sync;
		tsr_set[emacsq_pkg::TSR_RETRY_LIM_BIT] = retry_limit_evt;
		tsr_set[emacsq_pkg::TSR_EXHAUST_BIT]   = tx_buf_exhausted_evt;
		tsr_set[emacsq_pkg::TSR_COMP_BIT]      = tx_complete_evt;
		tsr_set[emacsq_pkg::TSR_UNDERRUN_BIT]  = tx_underrun_evt;
		tsr_clr = '0;
		if (wr_fire && reg_sel(aw_addr, emacsq_pkg::OFF_TRANSMIT_STATUS)) begin
			tsr_clr = wr_bits[emacsq_pkg::TSR_WIDTH-1:0];
		end
		tsr_clr[emacsq_pkg::TSR_TX_ACTIVE_BIT] = 1'b1;
		next_tsr_flag = (tsr_flag & ~tsr_clr) | tsr_set;
		rsr_set = '0;
		rsr_set[emacsq_pkg::RSR_UNAVAIL_BIT]  = rx_buf_unavail_evt;
		rsr_set[emacsq_pkg::RSR_RECEIVED_BIT] = rx_frame_stored_evt;
		rsr_set[emacsq_pkg::RSR_OVERRUN_BIT]  = rx_overrun_evt;
		rsr_clr = '0;
		if (wr_fire && reg_sel(aw_addr, emacsq_pkg::OFF_RECEIVE_STATUS)) begin
			rsr_clr = wr_bits[emacsq_pkg::RSR_WIDTH-1:0];
		end
		next_rsr_flag = (rsr_flag & ~rsr_clr) | rsr_set;
		isr_set = '0;
		isr_set[emacsq_pkg::ISR_MGMT_DONE_BIT] = mgmt_done_evt;
		isr_set[emacsq_pkg::ISR_RX_DONE_BIT]   = rx_frame_stored_evt;
		isr_set[emacsq_pkg::ISR_RX_USED_BIT]   = rx_used_bit_evt;
		isr_set[emacsq_pkg::ISR_TX_USED_BIT]   = tx_used_bit_evt;
		isr_set[emacsq_pkg::ISR_TUND_BIT]  = tx_underrun_evt;
		isr_set[emacsq_pkg::ISR_RETRY_LIM_BIT] = retry_limit_evt;
		isr_set[emacsq_pkg::ISR_TXERR_BIT] = tx_buf_exhausted_evt;
		isr_set[emacsq_pkg::ISR_TCOMP_BIT] = tx_complete_evt;
		isr_set[emacsq_pkg::ISR_ROVR_BIT]  = rx_overrun_evt;
		isr_set[emacsq_pkg::ISR_HRESP_BIT] = bus_error_evt;
		next_isr_flag = (isr_read ? '0 : isr_flag) | isr_set;
	end

	assign isr_read = rd_fire && reg_sel(s_axi_araddr, emacsq_pkg::OFF_INTERRUPT_STAT);

	// Transmit abort and receive recovery controls for the frame engines.
	always_comb begin
		next_tx_halt    = tx_halt;
		next_tx_bad_crc = tx_bad_crc;
		next_tx_er      = tx_er;
		if (!tx_active) begin
			next_tx_halt    = 1'b0;
			next_tx_bad_crc = 1'b0;
			next_tx_er      = 1'b0;
		end
		if (tx_buf_exhausted_evt) begin
			next_tx_halt    = 1'b1;
			next_tx_bad_crc = 1'b1;
			next_tx_er      = 1'b1;
		end
		if (tx_underrun_evt) begin
			next_tx_bad_crc = 1'b1;
		end
		next_rx_refetch = rx_refetch;
		if (rx_desc_ok) begin
			next_rx_refetch = 1'b0;
		end
		if (rx_buf_unavail_evt) begin
			next_rx_refetch = 1'b1;
		end
		next_rx_buf_recover = rx_overrun_evt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tsr_flag       <= emacsq_pkg::TSR_RESET;
			rsr_flag       <= emacsq_pkg::RSR_RESET;
			isr_flag       <= emacsq_pkg::ISR_RESET;
			tx_halt        <= 1'b0;
			tx_bad_crc     <= 1'b0;
			tx_er          <= 1'b0;
			rx_refetch     <= 1'b0;
			rx_buf_recover <= 1'b0;
		end else begin
			tsr_flag       <= next_tsr_flag;
			rsr_flag       <= next_rsr_flag;
			isr_flag       <= next_isr_flag;
			tx_halt        <= next_tx_halt;
			tx_bad_crc     <= next_tx_bad_crc;
			tx_er          <= next_tx_er;
			rx_refetch     <= next_rx_refetch;
			rx_buf_recover <= next_rx_buf_recover;
		end
	end

	assign rq_load = wr_fire && reg_sel(aw_addr, emacsq_pkg::OFF_RX_QUEUE_PTR);
	assign tq_load = wr_fire && reg_sel(aw_addr, emacsq_pkg::OFF_TX_QUEUE_PTR) && !tx_active;

	emacsq_qptr u_rx_qptr (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.load      (rq_load),
		.load_addr (wr_bits),
		.advance   (rx_buf_used),
		.wrap      (rx_desc_wrap),
		.mark      (1'b0),
		.cur       (rx_desc_addr),
		.first     ()
	);

	emacsq_qptr u_tx_qptr (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.load      (tq_load),
		.load_addr (wr_bits),
		.advance   (tx_buf_used),
		.wrap      (tx_desc_wrap),
		.mark      (tx_complete_evt),
		.cur       (tx_desc_addr),
		.first     (tx_first)
	);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_mdio_read_level: assert property (rd_fire && reg_sel(s_axi_araddr, 8'h08) |=>
		s_axi_rdata[1] == $past(mdio_sync)) else $error("mdio status bit wrong");
	chk_idle_read_level: assert property (rd_fire && reg_sel(s_axi_araddr, 8'h08) |=>
		s_axi_rdata[2] == !$past(mgmt_busy)) else $error("idle status bit wrong");
	chk_w1c_no_set: assert property (1'b1 |=>
		(tsr_flag & ~$past(tsr_flag) & ~$past(tsr_set)) == '0) else $error("flag set without event");
	chk_w1c_clears: assert property (wr_fire && reg_sel(aw_addr, 8'h20) |=>
		(rsr_flag & $past(wr_bits[2:0]) & ~$past(rsr_set)) == '0) else $error("w1c did not clear");
	chk_tx_used_both: assert property (tx_used_bit_evt |=> tsr_flag[0] && isr_flag[3])
		else $error("used bit event lost");
	chk_collision_sticky: assert property (col_sync |=> tsr_flag[1])
		else $error("collision flag not set");
	chk_tgo_live: assert property (rd_fire && reg_sel(s_axi_araddr, 8'h14) |=>
		s_axi_rdata[3] == $past(tx_active)) else $error("transmit go bit not live");
	chk_exhaust_abort: assert property (tx_buf_exhausted_evt |=>
		tx_halt && tx_er && tx_bad_crc && tsr_flag[4]) else $error("exhaustion abort missing");
	chk_comp_holds: assert property (tsr_flag[5] && !(wr_fire && reg_sel(aw_addr, 8'h14)) |=>
		tsr_flag[5]) else $error("complete flag dropped");
	chk_underrun_crc: assert property (tx_underrun_evt |=> tsr_flag[6] && tx_bad_crc)
		else $error("underrun not flagged");
	chk_tbqp_locked: assert property (wr_fire && reg_sel(aw_addr, 8'h1C) && tx_active
		&& !tx_complete_evt |=> tx_first == $past(tx_first))
		else $error("tx pointer written while active");
	chk_bna_refetch: assert property (rx_buf_unavail_evt |=> rsr_flag[0] && rx_refetch)
		else $error("buffer unavailable not flagged");
	chk_rec_set: assert property (rx_frame_stored_evt |=> rsr_flag[1] && isr_flag[1])
		else $error("frame received not flagged");
	chk_ovr_recover: assert property (rx_overrun_evt |=> rsr_flag[2] && rx_buf_recover)
		else $error("overrun not handled");
	chk_isr_read_clear: assert property (isr_read && !mgmt_done_evt && !rx_used_bit_evt |=>
		!isr_flag[0] && !isr_flag[2]) else $error("interrupt flags not cleared on read");
	chk_event_beats_clear: assert property (isr_read && mgmt_done_evt |=> isr_flag[0])
		else $error("event lost during clear");

	cov_write_tsr: cover property (wr_fire && reg_sel(aw_addr, 8'h14));
	cov_read_isr: cover property (isr_read && isr_flag != '0);
	cov_tbqp_refused: cover property (wr_fire && reg_sel(aw_addr, 8'h1C) && tx_active);
	cov_exhaust: cover property (tx_buf_exhausted_evt);
endmodule : emacsq_top

//--- emacsq_phy.sv
/* Far-side pin model for the management data input and collision lines.
   Assumes the bench requests pin levels; the pins move on a free 160 ns link clock. */
`timescale 1ns/10ps
module emacsq_phy (
	input  wire logic mdio_req,
	input  wire logic col_req,
	output logic      mdio_in,
	output logic      collision
);
	logic lclk = 1'b0;
	always #80 lclk = ~lclk;
	initial begin
		mdio_in = 1'b1;
		collision = 1'b0;
	end
	always @(posedge lclk) begin
		mdio_in <= mdio_req;
		collision <= col_req;
	end
endmodule : emacsq_phy

//--- tb_top.sv
/* Self-checking bench for the status, flag and queue pointer block.
   Assumes the AXI4-Lite slave and event pulses work on aclk; the pin model runs on its own 160 ns link clock. */
`timescale 1ns/10ps
module tb_top;
	logic        aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
	logic        awr, wrdy, bv, arr, rv, mdio, col, mreq = 1'b1, creq = 1'b0;
	logic        busy = 1'b0, act = 1'b0, er, halt, bad, refetch, recov;
	logic [7:0]  awa = '0, ara = '0;
	logic [31:0] wd = '0, rd, rxa, txa, v, s, t;
	logic [1:0]  br, rr;
	logic [15:0] ev = '0;
	int          miscompares = 0, n_compared = 0, i;
	always #10 aclk = ~aclk;
	emacsq_phy u_emacsq_phy (.mdio_req(mreq), .col_req(creq), .mdio_in(mdio), .collision(col));
	emacsq_top u_emacsq_top (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .mdio_in(mdio),
		.collision(col), .mgmt_busy(busy), .mgmt_done_evt(ev[0]), .tx_active(act),
		.tx_used_bit_evt(ev[1]), .retry_limit_evt(ev[2]), .tx_buf_exhausted_evt(ev[3]),
		.tx_complete_evt(ev[4]), .tx_underrun_evt(ev[5]), .tx_buf_used(ev[6]),
		.tx_desc_wrap(ev[7]), .rx_buf_unavail_evt(ev[8]), .rx_desc_ok(ev[9]),
		.rx_frame_stored_evt(ev[10]), .rx_overrun_evt(ev[11]), .rx_used_bit_evt(ev[12]),
		.rx_buf_used(ev[13]), .rx_desc_wrap(ev[14]), .bus_error_evt(ev[15]),
		.rx_desc_addr(rxa), .tx_desc_addr(txa), .tx_halt(halt), .tx_bad_crc(bad),
		.tx_er(er), .rx_refetch(refetch), .rx_buf_recover(recov));
	function automatic [31:0] tx_exp(input [31:0] m, input a);
		tx_exp = {25'h0, m[5], m[4], m[3], a, m[2], 1'b1, m[1]};
	endfunction : tx_exp
	task ck(input [31:0] g, input [31:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : ck
	task pu(input [15:0] m);
		ev <= m;
		@(posedge aclk);
		ev <= '0;
		@(posedge aclk);
	endtask : pu
	task w(input [7:0] a, input [31:0] d);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
		end while (awv && !awr || wv && !wrdy);
		do @(posedge aclk); while (!bv);
	endtask : w
	task r(input [7:0] a);
		ara <= a;
		arv <= 1'b1;
		do @(posedge aclk); while (!arr);
		arv <= 1'b0;
		do @(posedge aclk); while (!rv);
		v = rd;
	endtask : r
	task results;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		results;
	end
	initial begin
		i = $urandom(32'hBF4F);
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		r(8'h08);
		ck(v, 32'h6);
		busy <= 1'b1;
		mreq <= 1'b0;
		repeat (20) @(posedge aclk);
		r(8'h08);
		ck(v, 32'h0);
		busy <= 1'b0;
		$display("status pins done");
		for (i = 0; i < 5; i++) begin
			s = (i == 0) ? 32'h3E : $urandom;
			act <= 1'b1;
			creq <= 1'b1;
			pu({10'h0, s[5:1], 1'b0});
			repeat (12) @(posedge aclk);
			creq <= 1'b0;
			repeat (12) @(posedge aclk);
			r(8'h14);
			ck(v, tx_exp(s, 1'b1));
			ck({er, halt, bad}, {s[3], s[3], s[3] | s[5]});
			r(8'h24);
			ck(v, {24'h0, s[4], s[3], s[2], s[5], s[1], 3'h0});
			w(8'h14, 32'h0);
			w(8'h14, 32'hFFFF_FFFF);
			r(8'h14);
			ck(v, 32'h8);
			act <= 1'b0;
			@(posedge aclk);
		end
		pu(16'h1403);
		r(8'h24);
		ck(v, 32'hF);
		r(8'h24);
		ck(v, 32'h0);
		ev <= 16'h0001;
		r(8'h24);
		ev <= '0;
		r(8'h24);
		ck(v, 32'h1);
		pu(16'h0100);
		pu(16'h0100);
		ck(refetch, 1'b1);
		pu(16'h0200);
		ck(refetch, 1'b0);
		pu(16'h0800);
		ck(recov, 1'b1);
		r(8'h20);
		ck(v, 32'h7);
		w(8'h20, 32'h2);
		r(8'h20);
		ck(v, 32'h5);
		$display("flags done");
		s = $urandom & 32'h0FFF_FFF8;
		w(8'h18, s);
		for (i = 0; i < 1023; i++) pu(16'h2000);
		ck(rxa, s + 32'h1FF8);
		pu(16'h2000);
		ck(rxa, s);
		pu(16'h2000);
		pu(16'h6000);
		ck(rxa, s);
		pu(16'h2000);
		r(8'h18);
		ck(v, s + 32'h8);
		t = $urandom & 32'h0FFF_FFF8;
		w(8'h1C, t);
		pu(16'h0040);
		ck(txa, t + 32'h8);
		r(8'h1C);
		ck(v, t);
		pu(16'h0010);
		act <= 1'b1;
		w(8'h1C, 32'h100);
		r(8'h1C);
		ck(v, t + 32'h8);
		act <= 1'b0;
		w(8'h40, 32'h0);
		ck({30'h0, br}, 32'h2);
		r(8'h40);
		ck(v, 32'h0);
		ck({30'h0, rr}, 32'h2);
		$display("pointers done");
		results;
	end
endmodule : tb_top
